// ### src/acl_action_count.v
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "acl_consts.vh"

module acl_action_count #(
  parameter NPORT = 3,
  parameter MS_US = `ACL_MS_US
) (
  input  wire              clk,
  input  wire              rst_b,
  input  wire [9:0]        reg_addr,
  input  wire [31:0]       reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output wire [31:0]       reg_rdata,
  input  wire              pkt_valid,
  input  wire [1:0]        pkt_port,
  input  wire              pkt_hit,
  input  wire [3:0]        pkt_rule,
  input  wire [47:0]       pkt_mac,
  input  wire [15:0]       pkt_type,
  input  wire [2:0]        pkt_qos_prio,
  input  wire [2:0]        pkt_pcp,
  input  wire [NPORT-1:0]  pkt_map,
  output wire              out_valid,
  output wire [2:0]        out_prio,
  output wire [2:0]        out_pcp,
  output wire [NPORT-1:0]  out_map,
  output wire              irq
);

  localparam NE = NPORT * `ACL_NENT;

  reg  [29:0]      match_q [0:NE-1];
  reg  [47:0]      mac_q   [0:NE-1];
  reg  [31:0]      act_q   [0:NE-1];
  reg  [31:0]      rdata_q;
  reg  [NPORT-1:0] stat_q;
  reg  [NPORT-1:0] mask_q;
  reg  [NPORT-1:0] gstat_q;
  reg  [NPORT-1:0] gmask_q;
  reg              irq_q;
  reg              ov_q;
  reg  [2:0]       prio_q;
  reg  [2:0]       pcp_q;
  reg  [NPORT-1:0] map_q;
  reg  [5:0]       us_cnt_q;
  reg  [9:0]       ms_cnt_q;
  reg              us_tick_q;
  reg              ms_tick_q;
  wire [NE-1:0]    evt;
  reg  [NPORT-1:0] port_evt;
  reg  [31:0]      rdata_d;

  wire [1:0]  rgn   = reg_addr[9:8];
  wire [5:0]  widx  = reg_addr[7:2];
  wire [1:0]  wsel  = reg_addr[1:0];
  wire [7:0]  creg  = reg_addr[7:0];
  wire        tbl_ok = (rgn == `ACL_RG_TABLE) && ({26'h0, widx} < NE);
  wire        ctl   = (rgn == `ACL_RG_CTRL);
  wire        clr_wr = reg_wr && ctl && (creg == `ACL_R_CLR);

  assign reg_rdata = rdata_q;
  assign irq       = irq_q;
  assign out_valid = ov_q;
  assign out_prio  = prio_q;
  assign out_pcp   = pcp_q;
  assign out_map   = map_q;

  // Time base: one tick per microsecond, one per millisecond
  // Ticks are shared, so a fresh countdown may run up to one unit short
  always @(posedge clk) begin
    if (!rst_b) begin
      us_cnt_q  <= 6'h00;
      ms_cnt_q  <= 10'h000;
      us_tick_q <= 1'b0;
      ms_tick_q <= 1'b0;
    end else begin
      us_tick_q <= 1'b0;
      ms_tick_q <= 1'b0;
      if (us_cnt_q == `ACL_US_CYC - 1) begin
        us_cnt_q  <= 6'h00;
        us_tick_q <= 1'b1;
        if (ms_cnt_q == MS_US - 1) begin
          ms_cnt_q  <= 10'h000;
          ms_tick_q <= 1'b1;
        end else begin
          ms_cnt_q <= ms_cnt_q + 10'h001;
        end
      end else begin
        us_cnt_q <= us_cnt_q + 6'h01;
      end
    end
  end

  // Table writes; entries come up disabled
  integer i;
  always @(posedge clk) begin
    if (!rst_b) begin
      for (i = 0; i < NE; i = i + 1) begin
        match_q[i] <= 30'h0;
        mac_q[i]   <= 48'h0;
        act_q[i]   <= 32'h0;
      end
    end else if (reg_wr && tbl_ok) begin
      case (wsel)
        `ACL_W_MATCH:  match_q[widx] <= reg_wdata[29:0];
        `ACL_W_MACHI:  mac_q[widx][47:32] <= reg_wdata[15:0];
        `ACL_W_MACLO:  mac_q[widx][31:0] <= reg_wdata;
        `ACL_W_ACTION: act_q[widx] <= reg_wdata;
        default:       act_q[widx] <= act_q[widx];
      endcase
    end
  end

  // Per-entry count engine
  genvar g;
  generate
    for (g = 0; g < NE; g = g + 1) begin : ent
      localparam integer PI = g / `ACL_NENT;
      reg  [10:0] c_q;
      reg         run_q;
      wire [31:0] a    = act_q[g];
      wire        cm   = (match_q[g][`ACL_LAY_HI:`ACL_LAY_LO] == `ACL_LAYER_L2) &&
                         (match_q[g][`ACL_FS_HI:`ACL_FS_LO] == `ACL_FSEL_CNT);
      wire        q    = pkt_valid && (pkt_port == PI[1:0]) && cm &&
                         (pkt_mac == mac_q[g]) &&
                         (pkt_type == match_q[g][`ACL_TYPE_HI:`ACL_TYPE_LO]);
      wire [10:0] lim  = a[`ACL_CNT_HI:`ACL_CNT_LO];
      wire [10:0] inc  = c_q + 11'h001;
      wire        tick = a[`ACL_TU_BIT] ? ms_tick_q : us_tick_q;
      wire        hitc = q && (inc == lim);
      wire        expd = !q && run_q && tick && (c_q <= 11'h001);
      // Only count-mode entries feed the interrupt path
      assign evt[g] = cm && (a[`ACL_CA_BIT] ? hitc : expd);
      always @(posedge clk) begin
        if (!rst_b || !cm) begin
          c_q   <= 11'h000;
          run_q <= 1'b0;
        end else if (a[`ACL_CA_BIT]) begin
          run_q <= 1'b0;
          if (q) begin
            c_q <= (inc == lim) ? 11'h000 : inc;
          end
        end else if (q) begin
          c_q   <= lim;
          run_q <= (lim != 11'h000);
        end else if (run_q && tick) begin
          c_q <= c_q - 11'h001;
          if (c_q <= 11'h001) begin
            run_q <= 1'b0;
          end
        end
      end
    end
  endgenerate

  integer p;
  integer e;
  always @* begin
    port_evt = {NPORT{1'b0}};
    for (p = 0; p < NPORT; p = p + 1) begin
      for (e = 0; e < `ACL_NENT; e = e + 1) begin
        port_evt[p] = port_evt[p] | evt[p * `ACL_NENT + e];
      end
    end
  end

  // Write-one-to-clear; zero bits leave their status alone
  reg  [NPORT-1:0] clr_vec;
  wire             mask_wr  = reg_wr && ctl && (creg == `ACL_R_MASK);
  wire             gmask_wr = reg_wr && ctl && (creg == `ACL_R_GMASK);

  always @* begin
    clr_vec = {NPORT{1'b0}};
    if (clr_wr) begin
      clr_vec = reg_wdata[NPORT-1:0];
    end
  end

  // Interrupt status; a new event beats a clear in the same cycle
  always @(posedge clk) begin
    if (!rst_b) begin
      stat_q  <= {NPORT{1'b0}};
      mask_q  <= {NPORT{1'b0}};
      gstat_q <= {NPORT{1'b0}};
      gmask_q <= {NPORT{1'b0}};
      irq_q   <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~clr_vec) | port_evt;
      if (mask_wr) begin
        mask_q <= reg_wdata[NPORT-1:0];
      end
      if (gmask_wr) begin
        gmask_q <= reg_wdata[NPORT-1:0];
      end
      gstat_q <= stat_q & mask_q;
      irq_q   <= |(gstat_q & gmask_q);
    end
  end

  // Register reads; unmapped addresses read zero
  always @* begin
    rdata_d = 32'h0;
    if (tbl_ok) begin
      case (wsel)
        `ACL_W_MATCH:  rdata_d = {2'h0, match_q[widx]};
        `ACL_W_MACHI:  rdata_d = {16'h0, mac_q[widx][47:32]};
        `ACL_W_MACLO:  rdata_d = mac_q[widx][31:0];
        `ACL_W_ACTION: rdata_d = act_q[widx];
        default:       rdata_d = 32'h0;
      endcase
    end else if (ctl) begin
      case (creg)
        `ACL_R_STAT:  rdata_d[NPORT-1:0] = stat_q;
        `ACL_R_MASK:  rdata_d[NPORT-1:0] = mask_q;
        `ACL_R_GSTAT: rdata_d[NPORT-1:0] = gstat_q;
        `ACL_R_GMASK: rdata_d[NPORT-1:0] = gmask_q;
        default:      rdata_d = 32'h0;
      endcase
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= reg_rd ? rdata_d : 32'h0;
    end
  end

  // Action stage for the rule chosen by the matcher
  wire [5:0]       aidx  = {pkt_port, pkt_rule};
  wire [31:0]      av    = act_q[aidx];
  wire [29:0]      mv    = match_q[aidx];
  wire             acm   = (mv[`ACL_LAY_HI:`ACL_LAY_LO] == `ACL_LAYER_L2) &&
                           (mv[`ACL_FS_HI:`ACL_FS_LO] == `ACL_FSEL_CNT);
  wire             apply = pkt_hit && ({26'h0, aidx} < NE) &&
                           (mv[`ACL_LAY_HI:`ACL_LAY_LO] != `ACL_LAYER_OFF) && !acm;
  wire [2:0]       ap    = av[`ACL_P_HI:`ACL_P_LO];
  wire [NPORT-1:0] fwd   = av[`ACL_FWD_LO +: NPORT];
  reg  [2:0]       prio_d;
  reg  [2:0]       pcp_d;
  reg  [NPORT-1:0] map_d;

  // Remark only on an action hit; count entries never remark
  always @* begin
    pcp_d = pkt_pcp;
    if (apply && av[`ACL_RPE_BIT]) begin
      pcp_d = av[`ACL_RP_HI:`ACL_RP_LO];
    end
  end

  always @* begin
    prio_d = pkt_qos_prio;
    map_d  = pkt_map;
    if (apply) begin
      case (av[`ACL_PM_HI:`ACL_PM_LO])
        `ACL_PM_RAISE: prio_d = (ap > pkt_qos_prio) ? ap : pkt_qos_prio;
        `ACL_PM_LOWER: prio_d = (ap < pkt_qos_prio) ? ap : pkt_qos_prio;
        `ACL_PM_FORCE: prio_d = ap;
        default:       prio_d = pkt_qos_prio;
      endcase
      case (av[`ACL_MM_HI:`ACL_MM_LO])
        `ACL_MM_OR:   map_d = pkt_map | fwd;
        `ACL_MM_AND:  map_d = pkt_map & fwd;
        `ACL_MM_REPL: map_d = fwd;
        default:      map_d = pkt_map;
      endcase
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      ov_q   <= 1'b0;
      prio_q <= 3'h0;
      pcp_q  <= 3'h0;
      map_q  <= {NPORT{1'b0}};
    end else begin
      ov_q   <= pkt_valid;
      prio_q <= prio_d;
      map_q  <= map_d;
      pcp_q  <= pcp_d;
    end
  end

endmodule // acl_action_count

// ### shared/acl_consts.vh
`ifndef ACL_CONSTS_VH
`define ACL_CONSTS_VH

// Timing
`define ACL_CLK_NS      20
`define ACL_US_NS       1000
`define ACL_MS_US       1000
`define ACL_US_CYC      (`ACL_US_NS / `ACL_CLK_NS)

// Entries per table
`define ACL_NENT        16

// Match layer / field select codes
`define ACL_LAYER_OFF   2'h0
`define ACL_LAYER_L2    2'h1
`define ACL_FSEL_CNT    2'h0

// Priority and map modes
`define ACL_PM_QOS      2'h0
`define ACL_PM_RAISE    2'h1
`define ACL_PM_LOWER    2'h2
`define ACL_PM_FORCE    2'h3
`define ACL_MM_KEEP     2'h0
`define ACL_MM_OR       2'h1
`define ACL_MM_AND      2'h2
`define ACL_MM_REPL     2'h3

// Action word layout
`define ACL_PM_HI       12
`define ACL_PM_LO       11
`define ACL_P_HI        10
`define ACL_P_LO        8
`define ACL_RPE_BIT     7
`define ACL_RP_HI       6
`define ACL_RP_LO       4
`define ACL_MM_HI       3
`define ACL_MM_LO       2
`define ACL_TU_BIT      1
`define ACL_CA_BIT      0
`define ACL_CNT_HI      12
`define ACL_CNT_LO      2
`define ACL_FWD_LO      16

// Entry word 0 layout
`define ACL_TYPE_HI     15
`define ACL_TYPE_LO     0
`define ACL_FS_HI       25
`define ACL_FS_LO       24
`define ACL_LAY_HI      29
`define ACL_LAY_LO      28

// Address map
`define ACL_RG_TABLE    2'h0
`define ACL_RG_CTRL     2'h1
`define ACL_W_MATCH     2'h0
`define ACL_W_MACHI     2'h1
`define ACL_W_MACLO     2'h2
`define ACL_W_ACTION    2'h3
`define ACL_R_STAT      8'h00
`define ACL_R_CLR       8'h01
`define ACL_R_MASK      8'h02
`define ACL_R_GSTAT     8'h03
`define ACL_R_GMASK     8'h04

`endif

// ### testbench/acl_pkt_src.sv
`timescale 1ns/1ps
module acl_pkt_src #(
  parameter NPORT = 3
) (
  input  wire             clk,
  output reg              pkt_valid,
  output reg  [1:0]       pkt_port,
  output reg              pkt_hit,
  output reg  [3:0]       pkt_rule,
  output reg  [47:0]      pkt_mac,
  output reg  [15:0]      pkt_type,
  output reg  [2:0]       pkt_qos_prio,
  output reg  [2:0]       pkt_pcp,
  output reg  [NPORT-1:0] pkt_map
);
  initial {pkt_valid, pkt_port, pkt_hit, pkt_rule, pkt_mac, pkt_type} = '0;
  initial {pkt_qos_prio, pkt_pcp, pkt_map} = '0;
  task send(input [1:0] po, input h, input [3:0] ru, input [47:0] ma, input [15:0] ty,
            input [2:0] q, input [2:0] c, input [NPORT-1:0] m);
    @(posedge clk);
    {pkt_valid, pkt_port, pkt_hit, pkt_rule} <= {1'b1, po, h, ru};
    {pkt_mac, pkt_type, pkt_qos_prio, pkt_pcp, pkt_map} <= {ma, ty, q, c, m};
    @(posedge clk);
    // Stale fields other than pkt_port show junk so nothing leans on them
    pkt_valid <= 1'b0;
    {pkt_hit, pkt_rule, pkt_mac, pkt_type} <= ~{h, ru, ma, ty};
    {pkt_qos_prio, pkt_pcp, pkt_map} <= ~{q, c, m};
  endtask
endmodule // acl_pkt_src

// ### testbench/acl_action_count_properties.sv
`timescale 1ns/1ps
module acl_action_count_props #(
  parameter NPORT = 3
) (
  input wire             clk,
  input wire             rst_b,
  input wire [9:0]       reg_addr,
  input wire             reg_wr,
  input wire             reg_rd,
  input wire [31:0]      reg_rdata,
  input wire             pkt_valid,
  input wire             pkt_hit,
  input wire [2:0]       pkt_qos_prio,
  input wire [2:0]       pkt_pcp,
  input wire [NPORT-1:0] pkt_map,
  input wire             out_valid,
  input wire [2:0]       out_prio,
  input wire [2:0]       out_pcp,
  input wire [NPORT-1:0] out_map,
  input wire             irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  valid_pipe_a: assert property (pkt_valid |=> out_valid)
    else $error("out_valid missing after packet");
  no_spurious_a: assert property (!pkt_valid |=> !out_valid)
    else $error("out_valid without packet");
  pass_through_a: assert property (pkt_valid && !pkt_hit |=>
    out_prio == $past(pkt_qos_prio) && out_pcp == $past(pkt_pcp) && out_map == $past(pkt_map))
    else $error("unmatched packet altered");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 0)
    else $error("read data without read");
  clear_wo_a: assert property (reg_rd && reg_addr == 10'h101 |=> reg_rdata == 0)
    else $error("clear register readable");
  stat_width_a: assert property (reg_rd && reg_addr inside {10'h100, 10'h103} |=>
    reg_rdata[31:NPORT] == 0) else $error("status bits beyond ports");
  unmapped_rd_a: assert property (reg_rd && reg_addr[9] |=> reg_rdata == 0)
    else $error("unmapped read not zero");
  irq_hold_a: assert property ($fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2) ||
    $past(reg_wr, 3) || $past(reg_wr, 4)) else $error("irq dropped without write");
  rst_clear_a: assert property (disable iff (1'b0) !rst_b |=>
    !out_valid && !irq && reg_rdata == 0) else $error("outputs not cleared by reset");
endmodule // acl_action_count_props
bind acl_action_count acl_action_count_props #(.NPORT(NPORT)) u_props (.*);

// ### testbench/acl_action_and_count_engine_test.sv
`timescale 1ns/1ps
module acl_action_and_count_engine_test;
  logic        clk, rst_b, reg_wr, reg_rd;
  logic [9:0]  reg_addr;
  logic [31:0] reg_wdata, rdat, act;
  logic [2:0]  q, c, m;
  wire  [31:0] reg_rdata;
  wire         pkt_valid, pkt_hit, out_valid, irq;
  wire  [1:0]  pkt_port;
  wire  [3:0]  pkt_rule;
  wire  [47:0] pkt_mac;
  wire  [15:0] pkt_type;
  wire  [2:0]  pkt_qos_prio, pkt_pcp, pkt_map, out_prio, out_pcp, out_map;
  integer      miscompares = 0, total_checks = 0, seed = 32353, i, tu;
  localparam [47:0] MAC = 48'h0A0B_0C0D_0E0F;
  localparam [15:0] TYP = 16'h88B5;

  // Short ms so the millisecond base fits the run
  acl_action_count #(.NPORT(3), .MS_US(4)) dut (.*);
  acl_pkt_src #(.NPORT(3)) u_src (.*);

  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  function automatic logic [8:0] mdl(input [31:0] a, input [2:0] q, c, m);
    logic [2:0] r, f;
    r = q;
    f = m;
    case (a[12:11])
      2'h1: if (a[10:8] > q) r = a[10:8];
      2'h2: if (a[10:8] < q) r = a[10:8];
      2'h3: r = a[10:8];
    endcase
    case (a[3:2])
      2'h1: f = m | a[18:16];
      2'h2: f = m & a[18:16];
      2'h3: f = a[18:16];
    endcase
    return {r, a[7] ? a[6:4] : c, f};
  endfunction

  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wr(input [9:0] a, input [31:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rdchk(input [9:0] a, input [31:0] e);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Zero action word means the packet must pass untouched
  task pkt(input [1:0] po, input h, input [3:0] ru, input [47:0] ma, input [15:0] ty,
           input [31:0] a);
    q = $random(seed);
    c = $random(seed);
    m = $random(seed);
    u_src.send(po, h, ru, ma, ty, q, c, m);
    #1 chk(out_valid, 1);
    chk({out_prio, out_pcp, out_map}, mdl(a, q, c, m));
  endtask
  task waitchk(input integer n, input [31:0] st, input logic ir);
    repeat (n) @(posedge clk);
    #1 chk(irq, ir);
    rdchk(10'h100, st);
  endtask
  task results;
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    results;
  end

  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rdchk(10'h102, 0);
    rdchk(10'h104, 0);
    wr(10'h100, 7);
    rdchk(10'h100, 0);
    wr(10'h0C3, 32'h1FFF);
    rdchk(10'h0C3, 0);
    rdchk(10'h200, 0);
    for (i = 0; i < 16; i++) begin
      act = $random(seed) & 32'h0007_1FFC;
      act[12:11] = i[3:2];
      act[3:2] = i[1:0];
      wr({4'h0, i[3:0], 2'h0}, ((i % 3 + 1) << 28) | 32'h0300_0000);
      wr({4'h0, i[3:0], 2'h3}, act);
      rdchk({4'h0, i[3:0], 2'h3}, act);
      pkt(0, 1, i[3:0], 0, 0, act);
      pkt(0, 0, i[3:0], 0, 0, 0);
    end
    wr(10'h03C, 0);
    pkt(0, 1, 15, 0, 0, 0);
    rdchk(10'h100, 0);
    wr(10'h041, 32'h0A0B);
    wr(10'h042, 32'h0C0D0E0F);
    wr(10'h043, 32'h0D);
    wr(10'h040, 32'h1000_0000 | TYP);
    wr(10'h104, 7);
    pkt(1, 1, 0, MAC, TYP, 0);
    pkt(1, 0, 0, MAC, TYP + 16'h1, 0);
    pkt(1, 0, 0, MAC ^ 48'h1, TYP, 0);
    pkt(0, 0, 0, MAC, TYP, 0);
    pkt(1, 0, 0, MAC, TYP, 0);
    waitchk(4, 0, 0);
    pkt(1, 0, 0, MAC, TYP, 0);
    waitchk(4, 2, 0);
    wr(10'h102, 7);
    waitchk(4, 2, 1);
    rdchk(10'h103, 2);
    wr(10'h101, 2);
    waitchk(4, 0, 0);
    rdchk(10'h101, 0);
    for (tu = 0; tu < 2; tu++) begin
      wr(10'h043, 32'h0C | (tu << 1));
      pkt(1, 0, 0, MAC, TYP, 0);
      repeat (tu ? 160 : 40) @(posedge clk);
      pkt(1, 0, 0, MAC, TYP, 0);
      waitchk(tu ? 160 : 40, 0, 0);
      waitchk(tu ? 800 : 200, 2, 1);
      wr(10'h101, 2);
    end
    results;
  end
endmodule // acl_action_and_count_engine_test
